//--- bench/ebm_checker.sv
// checker of the external bus mode controller
`timescale 1ns/1ps
module ebm_checker (
    input wire logic        CORE_CLK,   // clock
    input wire logic        RST_N,      // reset
    input wire logic        EXT_ACCESS, // strap
    input wire logic        CPU_REQ,    // request
    input wire logic        CPU_ACK,    // done
    input wire logic        ALE,        // strobe
    input wire logic        RD_N,       // read
    input wire logic        WR_LOW_N,   // write
    input wire logic [15:0] AD_OE       // enables
);
    logic single_reg;
    always_ff @(posedge CORE_CLK) if (!RST_N) single_reg <= EXT_ACCESS;
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    a_ack_pulse: assert property (CPU_ACK |=> !CPU_ACK) else $error("ack too long");
    a_ack_idle: assert property (CPU_ACK |-> RD_N && WR_LOW_N && !ALE) else $error("ack in cycle");
    a_req_done: assert property ($rose(CPU_REQ) |-> ##[1:20] CPU_ACK) else $error("no ack");
    a_ale_cmd: assert property ($fell(ALE) |-> ##[1:3] !(RD_N && WR_LOW_N)) else $error("no command");
    a_rd_len: assert property ($fell(RD_N) |=> !RD_N ##1 RD_N) else $error("read length");
    a_rd_float: assert property ($rose(RD_N) |-> AD_OE[7:0] == 8'h00) else $error("read driven");
    a_wr_keep: assert property ($rose(WR_LOW_N) |-> AD_OE[7:0] == 8'hff) else $error("write dropped");
    a_single_quiet: assert property (single_reg |-> AD_OE == 16'h0000 && !ALE) else $error("bus used");
    cover property ($fell(RD_N));
    cover property ($fell(WR_LOW_N));
    cover property (single_reg && CPU_ACK);
endmodule : ebm_checker
bind ebm_ctrl ebm_checker ebm_checker_i (.*);

//--- bench/ebm_mem_model.sv
// memory model on the primary bus port
`timescale 1ns/1ps
module ebm_mem_model (
    input  wire logic        CORE_CLK, // clock
    input  wire logic        ALE,      // strobe
    input  wire logic        RD_N,     // read
    input  wire logic        WR_LOW_N, // write
    input  wire logic [15:0] AD_OUT,   // port out
    input  wire logic [15:0] ADDR_OUT, // addr port
    input  wire logic        ADDR_OE,  // addr enable
    output logic      [15:0] AD_IN,    // port in
    output logic      [15:0] wr_data   // written word
);
    logic [15:0] lat_reg, last_reg = '0;
    always @(negedge ALE) lat_reg = ADDR_OE ? ADDR_OUT : AD_OUT;
    always @(posedge CORE_CLK) last_reg <= AD_IN;
    // released bus toggles, never stale
    assign AD_IN = RD_N ? ~last_reg : {lat_reg[7:0] + 8'h11, lat_reg[7:0]};
    // data taken while the write command is low
    always @(posedge CORE_CLK) if (!WR_LOW_N) wr_data <= AD_OUT;
endmodule : ebm_mem_model

//--- bench/testbench.sv
// self-checking bench of the external bus mode controller
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin mismatches++; $display("mismatch at %0t: got %0h expected %0h", $time, (a), (b)); end end
module testbench;
    logic        CORE_CLK = '0, RST_N = '0, EXT_ACCESS = '0, PSEL = '0, PENABLE = '0, PWRITE = '0;
    logic        CPU_REQ = '0, CPU_WE = '0, CPU_WORD = 1'b1, e, PREADY, PSLVERR, CPU_ACK, ADDR_OE, ALE, RD_N, WR_LOW_N;
    logic [7:0]  PADDR = '0, SEG_OUT, SEG_OE;
    logic [31:0] PWDATA = '0, PRDATA, q;
    logic [23:0] CPU_ADDR = '0;
    logic [15:0] CPU_WDATA = '0, CPU_RDATA, AD_IN, mdl_in, AD_OUT, AD_OE, ADDR_OUT, wr_data;
    logic [4:0]  CS_N, CS_OE;
    int          mismatches = 0, compares = 0, cycles = 0, n0, n1;
    assign AD_IN = RST_N ? mdl_in : 16'h18c0; // straps: 2 segment lines, 3 selects, 16-bit mux
    ebm_ctrl ebm_ctrl_i (.*);
    ebm_mem_model ebm_mem_model_i (.*, .AD_IN(mdl_in));
    initial forever #25 CORE_CLK = ~CORE_CLK;
    always @(posedge CORE_CLK) if (++cycles == 3000) begin mismatches++; results(); end
    task automatic results();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : results
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge CORE_CLK) {PSEL, PWRITE, PADDR, PWDATA} <= {1'b1, w, a, d};
        @(posedge CORE_CLK) PENABLE <= 1'b1;
        do @(posedge CORE_CLK); while (PREADY !== 1'b1);
        q = PRDATA;
        e = PSLVERR;
        {PSEL, PENABLE} <= 2'b00;
    endtask : apb
    task automatic cpu(input logic [23:0] a, input logic w, input logic [15:0] d, output int n);
        n = 0;
        @(posedge CORE_CLK) {CPU_REQ, CPU_ADDR, CPU_WE, CPU_WDATA} <= {1'b1, a, w, d};
        do begin @(posedge CORE_CLK); n++; end while (CPU_ACK !== 1'b1);
        CPU_REQ <= 1'b0;
    endtask : cpu
    initial begin
        repeat (3) @(posedge CORE_CLK);
        RST_N <= 1'b1;
        apb(1'b0, 8'h00, '0); `CHK(q, 32'h13)
        apb(1'b0, 8'h28, '0); `CHK(q, 32'h3)
        apb(1'b0, 8'h30, '0); `CHK(e, 1'b1)
        `CHK({SEG_OE, CS_OE}, 13'h67)
        cpu(24'h010204, 1'b1, 16'hbeef, n0); `CHK(wr_data, 16'hbeef)
        `CHK({ADDR_OE, SEG_OUT}, 9'h01)
        cpu(24'h010204, 1'b0, 16'h0, n0); `CHK(CPU_RDATA, 16'h1504)
        CPU_WORD <= 1'b0;
        cpu(24'h010205, 1'b1, 16'hab00, n1); `CHK(wr_data, 16'habab)
        cpu(24'h010205, 1'b0, 16'h0, n1); `CHK(CPU_RDATA, 16'h1600)
        CPU_WORD <= 1'b1;
        $display("default area test done");
        apb(1'b1, 8'h04, 32'h10);
        apb(1'b1, 8'h14, 32'h200);
        apb(1'b1, 8'h08, 32'h1a);
        apb(1'b1, 8'h18, 32'h300);
        cpu(24'h020010, 1'b0, 16'h0, n1); `CHK({ADDR_OE, CPU_RDATA}, 17'h11110)
        `CHK(CS_N, 5'h1d)
        cpu(24'h030020, 1'b0, 16'h0, n1); `CHK(CPU_RDATA, 16'h3120)
        `CHK(CS_N, 5'h1b)
        `CHK(n1, n0 + 1)
        cpu(24'h010204, 1'b0, 16'h0, n1); `CHK(n1, n0 + 1)
        apb(1'b1, 8'h24, 32'h1);
        cpu(24'h010204, 1'b0, 16'h0, n1); `CHK(SEG_OUT, 8'h00)
        $display("window test done");
        {EXT_ACCESS, RST_N} <= 2'b10;
        repeat (3) @(posedge CORE_CLK);
        RST_N <= 1'b1;
        apb(1'b0, 8'h00, '0); `CHK(q, 32'h3)
        cpu(24'h010204, 1'b0, 16'h0, n1); `CHK({AD_OE, SEG_OE, CS_OE}, 29'h0)
        $display("single chip test done");
        results();
    end
endmodule : testbench

//--- hw/ebm_ctrl.sv
// external bus mode controller with apb register slave
//
// Decided for this implementation: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module ebm_ctrl (
    input  wire logic        CORE_CLK,    // core clock, 20 MHz
    input  wire logic        RST_N,       // synchronous reset, active low
    input  wire logic        EXT_ACCESS,  // external_access_pin, sampled in reset
    input  wire logic        PSEL,        // apb select
    input  wire logic        PENABLE,     // apb enable
    input  wire logic        PWRITE,      // apb direction
    input  wire logic [7:0]  PADDR,       // apb byte address
    input  wire logic [31:0] PWDATA,      // apb write data
    output logic      [31:0] PRDATA,      // apb read data
    output logic             PREADY,      // apb ready
    output logic             PSLVERR,     // apb error, unmapped address
    input  wire logic        CPU_REQ,     // internal access request
    input  wire logic [23:0] CPU_ADDR,    // physical address
    input  wire logic        CPU_WE,      // write access
    input  wire logic        CPU_WORD,    // word access, else byte
    input  wire logic [15:0] CPU_WDATA,   // write data, byte in lane of a0
    output logic             CPU_ACK,     // access done pulse
    output logic      [15:0] CPU_RDATA,   // read data
    input  wire logic [15:0] AD_IN,       // primary_ad_port input
    output logic      [15:0] AD_OUT,      // primary_ad_port output
    output logic      [15:0] AD_OE,       // primary_ad_port enables
    output logic      [15:0] ADDR_OUT,    // address_port
    output logic             ADDR_OE,     // address_port enable
    output logic      [7:0]  SEG_OUT,     // segment address lines
    output logic      [7:0]  SEG_OE,      // segment line enables
    output logic      [4:0]  CS_N,        // chip selects, active low
    output logic      [4:0]  CS_OE,       // chip select enables
    output logic             ALE,         // address latch strobe
    output logic             RD_N,        // read command, active low
    output logic             WR_LOW_N     // write_low_strobe, active low
);

    // ****************************************
    // registers
    // ****************************************
    logic [ebm_pkg::CFG_W-1:0] cfg_reg [0:4];
    logic [ebm_pkg::RNG_W-1:0] rng_reg [1:4];
    logic                      segmentation_disable_reg;
    logic [1:0]                sal_reg;
    logic [1:0]                chip_select_count_reg;
    logic                      single_reg;
    logic                      prev_demux_reg;
    logic                      pready_reg;
    logic                      pslverr_reg;
    logic [31:0]               prdata_reg;
    ebm_pkg::ebm_state_t       state_reg;
    ebm_pkg::ebm_state_t       state_next;
    logic [2:0]                cnt_reg;
    logic [2:0]                cnt_next;
    logic                      byte_hi_reg;
    logic                      byte_hi_next;
    logic                      ack_reg;
    logic                      ack_next;
    logic [23:0]               cur_addr_reg;
    logic                      cur_we_reg;
    logic                      cur_word_reg;
    logic [15:0]               cur_wdata_reg;
    logic [1:0]                cur_bus_type_field_reg;
    logic                      cur_alen_reg;
    logic                      cur_rwdly_reg;
    logic [2:0]                cur_idx_reg;
    logic [15:0]               rdata_reg;
    logic [15:0]               rdata_next;
    logic [15:0]               ad_out_reg;
    logic [15:0]               ad_out_next;
    logic [15:0]               ad_oe_reg;
    logic [15:0]               ad_oe_next;
    logic [15:0]               addr_out_reg;
    logic                      addr_oe_reg;
    logic [7:0]                seg_out_reg;
    logic [7:0]                seg_oe_reg;
    logic [4:0]                cs_n_reg;
    logic [4:0]                cs_oe_reg;
    logic                      ale_reg;
    logic                      rd_n_reg;
    logic                      wr_n_reg;

    // ****************************************
    // address decode and selection
    // ****************************************
    logic [4:1] win_hit;
    logic [4:0] demux_cfg;
    logic [2:0] sel_idx;
    logic [31:0] rd_val;
    logic        rd_ok;

    wire apb_acc  = PSEL & PENABLE & ~pready_reg;
    wire apb_done = PSEL & PENABLE & pready_reg;
    wire reg_wr   = apb_done & PWRITE;
    wire int_hit  = (CPU_ADDR[23:12] == ebm_pkg::INT_TAG);

    assign demux_cfg[0] = cfg_reg[0][ebm_pkg::CFG_ACT_BIT] & ~cfg_reg[0][ebm_pkg::CFG_BUS_TYPE_FIELD_LSB];

    genvar k;
    generate
        for (k = 1; k <= 4; k++) begin : g_win
            wire [11:0] msk  = ~((12'h001 << rng_reg[k][ebm_pkg::RNG_SIZE_LSB +: 4]) - 12'h001);
            wire [11:0] base = rng_reg[k][ebm_pkg::RNG_BASE_LSB +: 12];
            assign win_hit[k]   = ((CPU_ADDR[23:12] & msk) == (base & msk));
            assign demux_cfg[k] = cfg_reg[k][ebm_pkg::CFG_ACT_BIT] & ~cfg_reg[k][ebm_pkg::CFG_BUS_TYPE_FIELD_LSB];
            always_ff @(posedge CORE_CLK) begin
                if (!RST_N) begin
                    cfg_reg[k] <= ebm_pkg::CFG_RST;
                    rng_reg[k] <= ebm_pkg::RNG_RST;
                end else if (reg_wr) begin
                    if (PADDR == ebm_pkg::OFF_DEF_CFG + ebm_pkg::REG_STEP * 8'(k))
                        cfg_reg[k] <= PWDATA[ebm_pkg::CFG_W-1:0];
                    if (PADDR == ebm_pkg::OFF_WIN_RNG + ebm_pkg::REG_STEP * 8'(k - 1))
                        rng_reg[k] <= PWDATA[ebm_pkg::RNG_W-1:0];
                end
            end
        end
    endgenerate

    // lowest window wins, default covers the gaps
    assign sel_idx = win_hit[1] ? 3'd1 : win_hit[2] ? 3'd2 : win_hit[3] ? 3'd3 : win_hit[4] ? 3'd4 : 3'd0;

    wire [ebm_pkg::CFG_W-1:0] sel_cfg = cfg_reg[sel_idx];
    wire acc_take = (state_reg == ebm_pkg::ST_IDLE) & CPU_REQ & ~ack_reg;
    wire ext_go   = ~single_reg & ~int_hit & sel_cfg[ebm_pkg::CFG_ACT_BIT];
    wire any_demux = |demux_cfg;

    // values of the access in flight, valid already in the accept cycle
    wire [23:0] nx_addr  = acc_take ? CPU_ADDR : cur_addr_reg;
    wire        nx_we    = acc_take ? CPU_WE : cur_we_reg;
    wire        nx_word  = acc_take ? CPU_WORD : cur_word_reg;
    wire [15:0] nx_wdata = acc_take ? CPU_WDATA : cur_wdata_reg;
    wire [1:0]  nx_bus_type_field  = acc_take ? sel_cfg[ebm_pkg::CFG_BUS_TYPE_FIELD_LSB +: 2] : cur_bus_type_field_reg;
    wire        nx_alen  = acc_take ? sel_cfg[ebm_pkg::CFG_ALEN_BIT] : cur_alen_reg;
    wire        nx_rwdly = acc_take ? sel_cfg[ebm_pkg::CFG_RWDLY_BIT] : cur_rwdly_reg;
    wire [2:0]  nx_idx   = acc_take ? sel_idx : cur_idx_reg;
    wire        nx_mux   = nx_bus_type_field[0];
    wire        nx_wide  = nx_bus_type_field[1];
    wire [23:0] eff_addr = {nx_addr[23:1], nx_addr[0] | byte_hi_next};
    wire [7:0]  wr_byte  = eff_addr[0] ? nx_wdata[15:8] : nx_wdata[7:0];
    wire [2:0]  ale_len  = ebm_pkg::ALE_CYC + {2'b00, nx_alen};
    wire        cyc_end  = (cnt_reg == ebm_pkg::CNT_ONE);
    wire        split    = ~cur_bus_type_field_reg[1] & cur_word_reg & ~byte_hi_reg;
    wire        cur_lane = cur_addr_reg[0] | byte_hi_reg;  // lane of the byte now on the bus
    wire        nx_active = (state_next != ebm_pkg::ST_IDLE);
    wire [7:0]  seg_mask = ebm_pkg::ebm_seg_mask(sal_reg);
    wire [4:0]  cs_mask  = ebm_pkg::ebm_cs_mask(chip_select_count_reg);

    // ****************************************
    // bus cycle sequencer
    // ****************************************
    always_comb begin
        state_next   = state_reg;
        cnt_next     = cnt_reg;
        byte_hi_next = byte_hi_reg;
        ack_next     = 1'b0;
        case (state_reg)
            ebm_pkg::ST_IDLE: begin
                if (acc_take) begin
                    byte_hi_next = 1'b0;
                    if (ext_go) begin
                        if (nx_mux & prev_demux_reg) begin
                            state_next = ebm_pkg::ST_LEAD;
                        end else begin
                            state_next = ebm_pkg::ST_ALE;
                            cnt_next   = ale_len;
                        end
                    end else begin
                        ack_next = 1'b1;
                    end
                end
            end
            ebm_pkg::ST_LEAD: begin
                state_next = ebm_pkg::ST_ALE;
                cnt_next   = ale_len;
            end
            ebm_pkg::ST_ALE: begin
                cnt_next = cnt_reg - ebm_pkg::CNT_ONE;
                if (cyc_end) begin
                    state_next = ebm_pkg::ST_HOLD;
                    cnt_next   = ebm_pkg::HOLD_CYC + {2'b00, ~cur_bus_type_field_reg[0] & cur_rwdly_reg};
                end
            end
            ebm_pkg::ST_HOLD: begin
                cnt_next = cnt_reg - ebm_pkg::CNT_ONE;
                if (cyc_end) begin
                    state_next = ebm_pkg::ST_CMD;
                    cnt_next   = ebm_pkg::CMD_CYC;
                end
            end
            ebm_pkg::ST_CMD: begin
                cnt_next = cnt_reg - ebm_pkg::CNT_ONE;
                if (cyc_end) begin
                    if (split) begin
                        state_next   = ebm_pkg::ST_ALE;
                        byte_hi_next = 1'b1;
                        cnt_next     = ale_len;
                    end else begin
                        state_next = ebm_pkg::ST_IDLE;
                        ack_next   = 1'b1;
                    end
                end
            end
            default: begin
                state_next = ebm_pkg::ST_IDLE;
            end
        endcase
    end

    // ****************************************
    // primary port drive and read capture
    // ****************************************
    always_comb begin
        ad_out_next = ad_out_reg;
        ad_oe_next  = ad_oe_reg;
        rdata_next  = acc_take ? 16'h0000 : rdata_reg;
        case (state_next)
            ebm_pkg::ST_LEAD: begin
                ad_oe_next = 16'h0000;
            end
            ebm_pkg::ST_ALE, ebm_pkg::ST_HOLD: begin
                if (nx_mux) begin
                    ad_out_next = eff_addr[15:0];
                    ad_oe_next  = 16'hffff;
                end else begin
                    ad_oe_next = 16'h0000;
                end
            end
            ebm_pkg::ST_CMD: begin
                if (nx_we) begin
                    if (nx_wide) begin
                        ad_out_next = nx_word ? nx_wdata : {wr_byte, wr_byte};
                        ad_oe_next  = 16'hffff;
                    end else begin
                        ad_out_next = {eff_addr[15:8], wr_byte};
                        ad_oe_next  = nx_mux ? 16'hffff : 16'h00ff;
                    end
                end else begin
                    ad_out_next = {eff_addr[15:8], ad_out_reg[7:0]};
                    ad_oe_next  = (nx_mux & ~nx_wide) ? 16'hff00 : 16'h0000;
                end
            end
            default: begin
                ad_oe_next = ad_oe_reg;
            end
        endcase
        // sample on the edge that also ends the command
        if ((state_reg == ebm_pkg::ST_CMD) & cyc_end & ~cur_we_reg) begin
            if (cur_bus_type_field_reg[1] & cur_word_reg)
                rdata_next = AD_IN;
            else if (cur_lane)
                rdata_next[15:8] = cur_bus_type_field_reg[1] ? AD_IN[15:8] : AD_IN[7:0];
            else
                rdata_next[7:0] = AD_IN[7:0];
        end
        if (single_reg)
            ad_oe_next = 16'h0000;
    end

    // ****************************************
    // apb read mux
    // ****************************************
    always_comb begin
        rd_val = 32'h0000_0000;
        rd_ok  = 1'b1;
        case (PADDR)
            8'h00, 8'h04, 8'h08, 8'h0c, 8'h10:
                rd_val = {27'h0, cfg_reg[PADDR[4:2]]};
            8'h14, 8'h18, 8'h1c, 8'h20:
                rd_val = {16'h0, rng_reg[3'(PADDR[4:2] - 3'd4)]};
            ebm_pkg::OFF_SYS_CFG:
                rd_val = {31'h0, segmentation_disable_reg};
            ebm_pkg::OFF_RST_CFG:
                rd_val = {28'h0, chip_select_count_reg, sal_reg};
            ebm_pkg::OFF_STATUS:
                rd_val = {24'h0, any_demux, prev_demux_reg, state_reg, single_reg};
            default: rd_ok = 1'b0;
        endcase
    end

    // ****************************************
    // clocked state
    // ****************************************
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            single_reg <= EXT_ACCESS;
            cfg_reg[0] <= {~EXT_ACCESS, 2'b00, AD_IN[ebm_pkg::STRAP_BUS_TYPE_FIELD +: 2]};
            sal_reg    <= AD_IN[ebm_pkg::STRAP_SAL +: 2];
            chip_select_count_reg  <= AD_IN[ebm_pkg::STRAP_CS +: 2];
            segmentation_disable_reg <= 1'b0;
        end else if (reg_wr) begin
            if (PADDR == ebm_pkg::OFF_DEF_CFG)
                cfg_reg[0] <= PWDATA[ebm_pkg::CFG_W-1:0];
            if (PADDR == ebm_pkg::OFF_SYS_CFG)
                segmentation_disable_reg <= PWDATA[ebm_pkg::SYS_SEGMENTATION_DISABLE];
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
        end else begin
            pready_reg  <= apb_acc;
            pslverr_reg <= apb_acc & ~rd_ok;
            prdata_reg  <= (apb_acc & ~PWRITE) ? rd_val : 32'h0000_0000;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (acc_take) begin
            cur_addr_reg  <= CPU_ADDR;
            cur_we_reg    <= CPU_WE;
            cur_word_reg  <= CPU_WORD;
            cur_wdata_reg <= CPU_WDATA;
            cur_bus_type_field_reg  <= nx_bus_type_field;
            cur_alen_reg  <= nx_alen;
            cur_rwdly_reg <= nx_rwdly;
            cur_idx_reg   <= nx_idx;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            state_reg      <= ebm_pkg::ST_IDLE;
            cnt_reg        <= 3'h0;
            byte_hi_reg    <= 1'b0;
            ack_reg        <= 1'b0;
            rdata_reg      <= 16'h0000;
            prev_demux_reg <= 1'b0;
        end else begin
            state_reg   <= state_next;
            cnt_reg     <= cnt_next;
            byte_hi_reg <= byte_hi_next;
            ack_reg     <= ack_next;
            rdata_reg   <= rdata_next;
            if ((state_reg == ebm_pkg::ST_CMD) & cyc_end)
                prev_demux_reg <= ~cur_bus_type_field_reg[0];
        end
    end

    // ****************************************
    // pin registers
    // ****************************************
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            ad_out_reg   <= 16'h0000;
            ad_oe_reg    <= 16'h0000;
            addr_out_reg <= 16'h0000;
            addr_oe_reg  <= 1'b0;
            seg_out_reg  <= 8'h00;
            seg_oe_reg   <= 8'h00;
            cs_n_reg     <= 5'h1f;
            cs_oe_reg    <= 5'h00;
            ale_reg      <= 1'b0;
            rd_n_reg     <= 1'b1;
            wr_n_reg     <= 1'b1;
        end else begin
            ad_out_reg  <= ad_out_next;
            ad_oe_reg   <= ad_oe_next;
            addr_oe_reg <= any_demux & ~single_reg;
            seg_oe_reg  <= single_reg ? 8'h00 : seg_mask;
            cs_oe_reg   <= single_reg ? 5'h00 : cs_mask;
            ale_reg     <= (state_next == ebm_pkg::ST_LEAD) | (state_next == ebm_pkg::ST_ALE);
            rd_n_reg    <= ~((state_next == ebm_pkg::ST_CMD) & ~nx_we);
            wr_n_reg    <= ~((state_next == ebm_pkg::ST_CMD) & nx_we);
            if (nx_active) begin
                addr_out_reg <= eff_addr[15:0];
                seg_out_reg  <= segmentation_disable_reg ? 8'h00 : (eff_addr[23:16] & seg_mask);
            end
            if (state_next == ebm_pkg::ST_ALE)
                cs_n_reg <= ~((5'h01 << nx_idx) & cs_mask);
        end
    end

    assign PRDATA    = prdata_reg;
    assign PREADY    = pready_reg;
    assign PSLVERR   = pslverr_reg;
    assign CPU_ACK   = ack_reg;
    assign CPU_RDATA = rdata_reg;
    assign AD_OUT    = ad_out_reg;
    assign AD_OE     = ad_oe_reg;
    assign ADDR_OUT  = addr_out_reg;
    assign ADDR_OE   = addr_oe_reg;
    assign SEG_OUT   = seg_out_reg;
    assign SEG_OE    = seg_oe_reg;
    assign CS_N      = cs_n_reg;
    assign CS_OE     = cs_oe_reg;
    assign ALE       = ale_reg;
    assign RD_N      = rd_n_reg;
    assign WR_LOW_N  = wr_n_reg;

endmodule : ebm_ctrl

//--- hw/ebm_pkg.sv
// constants and types of the external bus mode controller
package ebm_pkg;

    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam logic [7:0] OFF_DEF_CFG = 8'h00;   // default_bus_config, windows follow at +4
    localparam logic [7:0] OFF_WIN_RNG = 8'h14;   // window_range_register 1..4
    localparam logic [7:0] OFF_SYS_CFG = 8'h24;   // system_config_register
    localparam logic [7:0] OFF_RST_CFG = 8'h28;   // reset_config_register, read only
    localparam logic [7:0] OFF_STATUS  = 8'h2c;   // controller status, read only
    localparam logic [7:0] REG_STEP    = 8'h04;

    // ****************************************
    // field layout
    // ****************************************
    localparam int unsigned CFG_W         = 5;
    localparam int unsigned CFG_BUS_TYPE_FIELD_LSB  = 0;    // bus_type_field [1:0]
    localparam int unsigned CFG_ALEN_BIT  = 2;    // strobe_length_ctl
    localparam int unsigned CFG_RWDLY_BIT = 3;    // command delay in demux cycles
    localparam int unsigned CFG_ACT_BIT   = 4;    // bus_active_bit
    localparam int unsigned RNG_W         = 16;
    localparam int unsigned RNG_SIZE_LSB  = 0;    // window size code [3:0]
    localparam int unsigned RNG_BASE_LSB  = 4;    // window base, address [23:12]
    localparam int unsigned SYS_SEGMENTATION_DISABLE    = 0;    // segmentation_disable
    localparam int unsigned RSTC_SAL_LSB  = 0;    // segment_line_select [1:0]
    localparam int unsigned RSTC_CS_LSB   = 2;    // chip_select_count [1:0]
    localparam int unsigned STRAP_BUS_TYPE_FIELD    = 6;    // primary port straps
    localparam int unsigned STRAP_CS      = 9;
    localparam int unsigned STRAP_SAL     = 11;

    // ****************************************
    // reset values and timing
    // ****************************************
    localparam logic [CFG_W-1:0] CFG_RST  = 5'h00;
    localparam logic [RNG_W-1:0] RNG_RST  = 16'h0000;
    localparam logic [11:0]      INT_TAG  = 12'h00f;  // internal area at 0x00f000
    localparam logic [2:0]       ALE_CYC  = 3'h1;
    localparam logic [2:0]       HOLD_CYC = 3'h1;
    localparam logic [2:0]       CMD_CYC  = 3'h2;
    localparam logic [2:0]       CNT_ONE  = 3'h1;

    typedef enum logic [1:0] {
        BT_8_DEMUX  = 2'b00,
        BT_8_MUX    = 2'b01,
        BT_16_DEMUX = 2'b10,
        BT_16_MUX   = 2'b11
    } ebm_bus_type_field_t;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_LEAD = 5'b00010,
        ST_ALE  = 5'b00100,
        ST_HOLD = 5'b01000,
        ST_CMD  = 5'b10000
    } ebm_state_t;

    function automatic logic [7:0] ebm_seg_mask(input logic [1:0] sel);
        case (sel)
            2'b11:   ebm_seg_mask = 8'h03;
            2'b10:   ebm_seg_mask = 8'hff;
            2'b01:   ebm_seg_mask = 8'h00;
            default: ebm_seg_mask = 8'h0f;
        endcase
    endfunction : ebm_seg_mask

    function automatic logic [4:0] ebm_cs_mask(input logic [1:0] sel);
        case (sel)
            2'b11:   ebm_cs_mask = 5'h1f;
            2'b10:   ebm_cs_mask = 5'h00;
            2'b01:   ebm_cs_mask = 5'h03;
            default: ebm_cs_mask = 5'h07;
        endcase
    endfunction : ebm_cs_mask

endpackage : ebm_pkg
